//--- smr4_ctrl_model.sv
// Purpose: controller model issuing register set commands
// Assumes: go_i, bad_i and word_i change at the falling edge
// Notes: idle pins show the inverse of the word
`timescale 1ns/100ps
`default_nettype none
module smr4_ctrl_model #(
    parameter bit GEAR_DOWN = 1'b0,
    // lowest write latency of the clock range, plain default
    parameter int WLAT_FLOOR = 9
) (
    // request from bench
    input wire logic go_i,
    input wire logic bad_i,
    input wire logic [21:0] word_i,
    // command pins
    output logic cmd_valid_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output smr4_pkg::smr4_pins_t pins_o,
    // write latency programmed alongside this word
    output logic [4:0] wlat_o
);
    logic [21:0] w;
    always_comb begin
        w = word_i & 22'h1dffff;
        if (GEAR_DOWN) begin
            // two clock leads only, latency codes 1 and 3 moved up
            w[12] = 1'b1;
            w[11] = 1'b1;
            if (w[6] && !w[8]) begin
                w[8:6] = w[8:6] + 3'h1;
            end
        end
        wlat_o = 5'(w[12] ? WLAT_FLOOR + 1 : WLAT_FLOOR);
        cmd_valid_o = go_i;
        ras_n_o = !go_i || bad_i;
        cas_n_o = !go_i;
        we_n_o = !go_i;
        pins_o = {w[21:17], w[13:0]} ^ {19{!go_i}};
    end
endmodule : smr4_ctrl_model
`default_nettype wire

//--- smr4_pkg.sv
// Purpose: constants and types for the mode register four decode block
// Assumes: one register set command per cycle, pins sampled on ref_clk_i
// Notes: field positions follow the 22-bit mode register layout
//
// What this block does
// RULE1: set command loads bank group, bank address, a17, a13..0 into bits.
// RULE2: controller holds row, column, write strobes low during set command.
// RULE3: controller writes zero to reserved bits 21 and 17.
// RULE4: bit 13 enables permanent row repair.
// RULE5: bit 12 picks one or two clock write strobe lead.
// RULE6: controller raises write latency when two clock write lead used.
// RULE7: bit 11 picks one or two clock read strobe lead.
// RULE8: bit 10 enables read lead training for controller strobe tuning.
// RULE9: bit 9 enables self refresh abort.
// RULE10: bits 8:6 code latency 0,3,4,5,6,8 clocks; 110,111 reserved.
// RULE11: controller avoids latency 3,5 and one clock leads in gear-down.
// RULE12: bit 5 enables temporary row repair.
// RULE13: bit 3 enables temperature controlled refresh.
// RULE14: bit 2 picks normal or extended temperature range.
// RULE15: bit 1 enters maximum power saving mode.
// RULE16: readout page 2 location 0 bit 7 reports permanent repair support.
// RULE17: readout page 2 location 0 bit 6 reports temporary repair support.
// RULE18: permanent repair fixes one row per bank, never undone.
// RULE19: temporary repair one row per bank, undone by reset/powerdown/rewrite.
// RULE20: power saving ignores all but exit command, still honours reset; code still clears temporary repairs on power_down_i.
// RULE21: bit 4 enables reference monitor, bit 0 enables builtin test repair.
package smr4_pkg;
    localparam int REG_W = 22;
    localparam logic [2:0] SEL_THIS = 3'h4;
    localparam int B_PERM = 13;
    localparam int B_WLEAD = 12;
    localparam int B_RLEAD = 11;
    localparam int B_RTRAIN = 10;
    localparam int B_SRABORT = 9;
    localparam int B_LAT_LO = 6;
    localparam int B_TEMP = 5;
    localparam int B_VMON = 4;
    localparam int B_TCR = 3;
    localparam int B_TCRRNG = 2;
    localparam int B_MPS = 1;
    localparam int B_BIST = 0;
    localparam logic [21:0] REG_RST = 22'h000000;
    localparam logic [1:0] READOUT_PAGE = 2'h2;
    localparam logic [1:0] READOUT_LOC = 2'h0;
    localparam int RO_PERM_BIT = 7;
    localparam int RO_TEMP_BIT = 6;

    typedef struct packed {
        logic perm_repair;
        logic wlead_two;
        logic rlead_two;
        logic rlead_train;
        logic sr_abort;
        logic [3:0] cmd_latency;
        logic lat_reserved;
        logic temp_repair;
        logic vref_mon;
        logic tcr_en;
        logic tcr_ext;
        logic max_power_save;
        logic builtin_repair;
    } smr4_cfg_t;

    typedef struct packed {
        logic [1:0] bank_group_pins;
        logic [1:0] bank_address_pins;
        logic a17;
        logic [13:0] addr;
    } smr4_pins_t;
endpackage : smr4_pkg

//--- smr4_top.sv
// Purpose: mode register four store, decode and repair bookkeeping
// Assumes: command pins synchronous to ref_clk_i
// Notes: power-down and power-saving exit arrive as decoded strobes
`timescale 1ns/100ps
`default_nettype none
module smr4_top #(
    parameter int BANKS = 16,
    parameter int ROW_W = 17,
    parameter bit PERM_SUPPORTED = 1'b1,
    parameter bit TEMP_SUPPORTED = 1'b1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // command pins
    input wire logic cmd_valid_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire smr4_pkg::smr4_pins_t pins_i,
    // other decoded commands
    input wire logic other_cmd_i,
    input wire logic mps_exit_i,
    input wire logic power_down_i,
    input wire logic repair_req_i,
    input wire logic [$clog2(BANKS)-1:0] repair_bank_i,
    input wire logic [ROW_W-1:0] repair_row_i,
    // readout page request
    input wire logic readout_req_i,
    input wire logic [1:0] readout_page_i,
    input wire logic [1:0] readout_loc_i,
    // register, decoded configuration, accept, readout and repair status
    output logic [smr4_pkg::REG_W-1:0] reg_o,
    output smr4_pkg::smr4_cfg_t cfg_o,
    output logic cmd_accept_o,
    output logic [7:0] readout_o,
    output logic [BANKS-1:0] perm_used_o,
    output logic [BANKS-1:0] temp_used_o
);
    logic [smr4_pkg::REG_W-1:0] reg_q, reg_d;
    logic mps_q, mps_d;
    logic acc_q, acc_d;
    logic [7:0] ro_q, ro_d;
    logic [BANKS-1:0] pu_d, tu_q, tu_d;
    // fuses start blank at power-up and are never reset
    logic [BANKS-1:0] pu_q = '0;
    smr4_pkg::smr4_cfg_t cfg_q, cfg_d;
    logic [ROW_W-1:0] prow_q [BANKS];
    logic [ROW_W-1:0] trow_q [BANKS];
    logic set_hit;
    logic rep;
    logic [smr4_pkg::REG_W-1:0] raw;

    assign raw = {pins_i.bank_group_pins, pins_i.bank_address_pins,
                  pins_i.a17, 3'h0, pins_i.addr}; // RULE1
    assign set_hit = cmd_valid_i && !ras_n_i && !cas_n_i && !we_n_i
        && (raw[20:18] == smr4_pkg::SEL_THIS); // RULE2
    assign rep = repair_req_i && !mps_q;

    function automatic logic [3:0] lat_decode(input logic [2:0] c);
        case (c) // RULE10
            3'h0: lat_decode = 4'h0;
            3'h1: lat_decode = 4'h3;
            3'h2: lat_decode = 4'h4;
            3'h3: lat_decode = 4'h5;
            3'h4: lat_decode = 4'h6;
            3'h5: lat_decode = 4'h8;
            default: lat_decode = 4'h0;
        endcase
    endfunction : lat_decode

    always_comb begin
        reg_d = reg_q;
        mps_d = mps_q;
        acc_d = 1'b0;
        if (mps_q) begin
            if (mps_exit_i) begin // RULE20
                mps_d = 1'b0;
                reg_d[smr4_pkg::B_MPS] = 1'b0;
            end
        end else if (set_hit) begin
            reg_d = raw; // RULE1
            reg_d[21] = 1'b0; // RULE3
            reg_d[17] = 1'b0; // RULE3
            mps_d = raw[smr4_pkg::B_MPS]; // RULE15
            acc_d = 1'b1;
        end
    end

    // decode from next values so every field leaves a flip-flop
    always_comb begin
        cfg_d.perm_repair = reg_d[smr4_pkg::B_PERM]; // RULE4
        cfg_d.wlead_two = reg_d[smr4_pkg::B_WLEAD]; // RULE5
        cfg_d.rlead_two = reg_d[smr4_pkg::B_RLEAD]; // RULE7
        cfg_d.rlead_train = reg_d[smr4_pkg::B_RTRAIN]; // RULE8
        cfg_d.sr_abort = reg_d[smr4_pkg::B_SRABORT]; // RULE9
        cfg_d.cmd_latency = lat_decode(reg_d[smr4_pkg::B_LAT_LO +: 3]); // RULE10
        cfg_d.lat_reserved = reg_d[smr4_pkg::B_LAT_LO + 2]
            & reg_d[smr4_pkg::B_LAT_LO + 1]; // RULE10
        cfg_d.temp_repair = reg_d[smr4_pkg::B_TEMP]; // RULE12
        cfg_d.vref_mon = reg_d[smr4_pkg::B_VMON]; // RULE21
        cfg_d.tcr_en = reg_d[smr4_pkg::B_TCR]; // RULE13
        cfg_d.tcr_ext = reg_d[smr4_pkg::B_TCRRNG]; // RULE14
        cfg_d.max_power_save = mps_d; // RULE15
        cfg_d.builtin_repair = reg_d[smr4_pkg::B_BIST]; // RULE21
    end

    always_comb begin
        ro_d = ro_q;
        if (readout_req_i && !mps_q) begin
            ro_d = 8'h00;
            if (readout_page_i == smr4_pkg::READOUT_PAGE &&
                readout_loc_i == smr4_pkg::READOUT_LOC) begin
                ro_d[smr4_pkg::RO_PERM_BIT] = PERM_SUPPORTED; // RULE16
                ro_d[smr4_pkg::RO_TEMP_BIT] = TEMP_SUPPORTED; // RULE17
            end
        end
    end

    always_comb begin
        pu_d = pu_q;
        tu_d = tu_q;
        if (power_down_i) begin
            tu_d = '0; // RULE19
        end
        if (rep && reg_q[smr4_pkg::B_PERM] && PERM_SUPPORTED) begin
            pu_d[repair_bank_i] = 1'b1; // RULE18
        end
        if (rep && reg_q[smr4_pkg::B_TEMP] && TEMP_SUPPORTED) begin
            tu_d[repair_bank_i] = 1'b1; // RULE19
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            reg_q <= smr4_pkg::REG_RST;
            mps_q <= 1'b0;
            acc_q <= 1'b0;
            ro_q <= 8'h00;
            tu_q <= '0; // RULE19
            cfg_q <= '0;
        end else begin
            reg_q <= reg_d;
            cfg_q <= cfg_d;
            mps_q <= mps_d;
            acc_q <= acc_d;
            ro_q <= ro_d;
            tu_q <= tu_d;
        end
    end

    // permanent fuses survive reset
    always_ff @(posedge ref_clk_i) begin
        pu_q <= pu_d; // RULE18
    end

    always_ff @(posedge ref_clk_i) begin
        if (rep && reg_q[smr4_pkg::B_PERM] && !pu_q[repair_bank_i]) begin
            prow_q[repair_bank_i] <= repair_row_i; // RULE18
        end
        if (rep && reg_q[smr4_pkg::B_TEMP]) begin
            trow_q[repair_bank_i] <= repair_row_i; // RULE19
        end
    end

    always_comb begin
        reg_o = reg_q;
        cfg_o = cfg_q;
        cmd_accept_o = acc_q;
        readout_o = ro_q;
        perm_used_o = pu_q;
        temp_used_o = tu_q;
    end

    logic unused_other;
    assign unused_other = other_cmd_i; // ignored while saving, RULE20

    set_loads_a: assert property (@(posedge ref_clk_i) // RULE1
        disable iff (reset_i)
        set_hit && !mps_q |=> reg_q[13:0] == $past(pins_i.addr))
        else $error("set command did not load address bits");
    reserved_zero_a: assert property (@(posedge ref_clk_i) // RULE3
        disable iff (reset_i) !reg_q[21] && !reg_q[17])
        else $error("reserved bit stored as one");
    mps_hold_a: assert property (@(posedge ref_clk_i) // RULE20
        disable iff (reset_i)
        mps_q && !mps_exit_i |=> $stable(reg_q))
        else $error("register changed during power saving");
    mps_exit_a: assert property (@(posedge ref_clk_i) // RULE15
        disable iff (reset_i)
        mps_q && mps_exit_i |=> !mps_q)
        else $error("power saving exit ignored");
    mps_reset_a: assert property (@(posedge ref_clk_i) // RULE20
        reset_i |=> !cfg_o.max_power_save && !mps_q)
        else $error("reset did not end power saving");
    perm_keep_a: assert property (@(posedge ref_clk_i) // RULE18
        $past(pu_q) != '0 |-> (pu_q & $past(pu_q)) == $past(pu_q))
        else $error("permanent repair lost");
    temp_pd_a: assert property (@(posedge ref_clk_i) // RULE19
        disable iff (reset_i)
        power_down_i && !rep |=> tu_q == '0)
        else $error("temporary repair kept over power-down");
    lat_map_a: assert property (@(posedge ref_clk_i) // RULE10
        disable iff (reset_i)
        reg_q[8:6] == 3'h5 |-> cfg_o.cmd_latency == 4'h8)
        else $error("latency code five wrong");
    readout_bits_a: assert property (@(posedge ref_clk_i) // RULE16 RULE17
        disable iff (reset_i)
        readout_req_i && !mps_q && readout_page_i == smr4_pkg::READOUT_PAGE
        && readout_loc_i == smr4_pkg::READOUT_LOC
        |=> readout_o[7] == PERM_SUPPORTED && readout_o[6] == TEMP_SUPPORTED)
        else $error("readout support bits wrong");
    other_page_a: assert property (@(posedge ref_clk_i) // RULE16 RULE17
        disable iff (reset_i)
        readout_req_i && !mps_q && readout_page_i != smr4_pkg::READOUT_PAGE
        |=> readout_o == 8'h00)
        else $error("readout of other page not zero");
    lead_decode_a: assert property (@(posedge ref_clk_i) // RULE5 RULE7
        disable iff (reset_i)
        cfg_o.wlead_two == reg_q[12] && cfg_o.rlead_two == reg_q[11])
        else $error("strobe lead decode wrong");

    set_c: cover property (@(posedge ref_clk_i) set_hit && !mps_q);
    readout_c: cover property (@(posedge ref_clk_i) readout_req_i && !mps_q);
    mps_c: cover property (@(posedge ref_clk_i) mps_q ##1 !mps_q);
    perm_c: cover property (@(posedge ref_clk_i) pu_q != '0);
endmodule : smr4_top
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the mode register four block
// Assumes: answers land on the taking edge and are read at the next falling edge
// Notes: bank width four for sixteen banks
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk_i = 0;
    logic reset_i = 1;
    logic go = 0, bad = 0, mx = 0, pdn = 0, rep = 0, rd = 0;
    logic [21:0] word = 22'h0;
    logic [1:0] pg = 2'h2;
    logic [4:0] wl;
    localparam int WLAT_LOW = 9;
    logic [3:0] rbank = 4'h3;
    logic cv, rn, cn, wn, acc;
    smr4_pkg::smr4_pins_t pins;
    smr4_pkg::smr4_cfg_t cfg;
    logic [21:0] regv;
    logic [7:0] ro;
    logic [15:0] pu, tu;
    int fails = 0;
    int checks_done = 0;
    int lat[8] = '{0, 3, 4, 5, 6, 8, 0, 0};
    int rb[10] = '{13, 12, 11, 10, 9, 5, 4, 3, 2, 0};
    int cb[10] = '{15, 14, 13, 12, 11, 5, 4, 3, 2, 0};
    initial forever #10 ref_clk_i = ~ref_clk_i;
    smr4_ctrl_model #(.WLAT_FLOOR(WLAT_LOW)) i_ctrl (.go_i(go), .bad_i(bad),
        .word_i(word), .cmd_valid_o(cv), .ras_n_o(rn), .cas_n_o(cn),
        .we_n_o(wn), .pins_o(pins), .wlat_o(wl));
    smr4_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .cmd_valid_i(cv), .ras_n_i(rn), .cas_n_i(cn), .we_n_i(wn),
        .pins_i(pins), .other_cmd_i(1'b0), .mps_exit_i(mx),
        .power_down_i(pdn), .repair_req_i(rep), .repair_bank_i(rbank),
        .repair_row_i(17'h00abc), .readout_req_i(rd),
        .readout_page_i(pg), .readout_loc_i(2'h0), .reg_o(regv),
        .cfg_o(cfg), .cmd_accept_o(acc), .readout_o(ro),
        .perm_used_o(pu), .temp_used_o(tu));
    function automatic logic [21:0] mw(logic [13:0] a);
        mw = {1'b0, smr4_pkg::SEL_THIS, 4'h0, a};
    endfunction : mw
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [21:0] w, logic b = 1'b0);
        @(negedge ref_clk_i);
        go = 1;
        word = w;
        bad = b;
        @(negedge ref_clk_i);
        go = 0;
        bad = 0;
    endtask : wr
    task automatic pulse(ref logic s);
        @(negedge ref_clk_i);
        s = 1;
        @(negedge ref_clk_i);
        s = 0;
    endtask : pulse
    task automatic final_report();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(negedge ref_clk_i);
        reset_i = 0;
        chk("reg", 0, regv);
        pulse(rd);
        chk("readout", 32'hc0, ro);
        pg = 2'h1;
        pulse(rd);
        chk("readout", 0, ro);
        pg = 2'h2;
        $display("test reset done");
        foreach (lat[i]) begin
            wr(mw(14'(i << 6)));
            chk("accept", 1, acc);
            chk("lat", lat[i], cfg.cmd_latency);
            chk("lat_rsv", i > 5, cfg.lat_reserved);
        end
        $display("test latency done");
        for (int k = 0; k < 5; k++) begin
            wr(mw(14'(1 << rb[k])));
            chk("reg", mw(14'(1 << rb[k])), regv);
            chk("wlat", WLAT_LOW + (rb[k] == 12), wl);
            chk("cfg", 1 << cb[k], cfg);
        end
        for (int k = 5; k < 10; k++) begin
            wr(mw(14'(1 << rb[k])));
            chk("reg", mw(14'(1 << rb[k])), regv);
            chk("cfg", 1 << cb[k], cfg);
        end
        wr(mw(14'h0400), 1'b1);
        chk("reg", mw(14'h0001), regv);
        wr({1'b0, 3'h5, 4'h0, 14'h0400});
        chk("accept", 0, acc);
        chk("reg", mw(14'h0001), regv);
        $display("test fields done");
        wr(mw(14'h2020));
        pulse(rep);
        chk("perm", 16'h0008, pu);
        chk("temp", 16'h0008, tu);
        pulse(pdn);
        chk("temp", 0, tu);
        chk("perm", 16'h0008, pu);
        pulse(rep);
        @(negedge ref_clk_i);
        reset_i = 1;
        repeat (2) @(negedge ref_clk_i);
        reset_i = 0;
        chk("temp", 0, tu);
        chk("perm", 16'h0008, pu);
        $display("test repair done");
        wr(mw(14'h0002));
        chk("mps", 1, cfg.max_power_save);
        wr(mw(14'h0008));
        chk("reg", mw(14'h0002), regv);
        pulse(rd);
        chk("readout", 0, ro);
        pulse(mx);
        chk("mps", 0, cfg.max_power_save);
        wr(mw(14'h0008));
        chk("reg", mw(14'h0008), regv);
        wr(mw(14'h0002));
        @(negedge ref_clk_i);
        reset_i = 1;
        @(negedge ref_clk_i);
        reset_i = 0;
        chk("mps", 0, cfg.max_power_save);
        chk("reg", 0, regv);
        $display("test power save done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
